/* design/dbr_debug_regs.sv */
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module dbr_debug_regs (
  input  wire logic                   clock_i,
  input  wire logic                   resetn_i,
  input  wire logic                   s_axi_awvalid_i,
  input  wire logic [dbr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  output logic                        s_axi_awready_o,
  input  wire logic                   s_axi_wvalid_i,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  output logic                        s_axi_wready_o,
  output logic                        s_axi_bvalid_o,
  output logic [1:0]                  s_axi_bresp_o,
  input  wire logic                   s_axi_bready_i,
  input  wire logic                   s_axi_arvalid_i,
  input  wire logic [dbr_pkg::ADDR_W-1:0] s_axi_araddr_i,
  output logic                        s_axi_arready_o,
  output logic                        s_axi_rvalid_o,
  output logic [31:0]                 s_axi_rdata_o,
  output logic [1:0]                  s_axi_rresp_o,
  input  wire logic                   s_axi_rready_i,
  input  wire logic                   debug_mode_i,
  input  wire logic                   host_req_i,
  input  wire logic                   debug_call_instruction_i,
  input  wire logic [7:0]             debug_call_instruction_thread_i,
  input  wire logic [3:0]             ibp_hit_i,
  input  wire logic [7:0]             ibp_thread_i,
  input  wire logic [3:0]             dwp_hit_i,
  input  wire logic [7:0]             dwp_thread_i,
  input  wire logic [7:0]             rbp_cond_a_i,
  input  wire logic [7:0]             rbp_cond_b_i,
  output logic                        debug_entry_o,
  output dbr_pkg::dbr_cause_type      cause_o,
  output logic [7:0]                  thread_sel_o,
  output logic [4:0]                  reg_sel_o,
  output logic [7:0]                  rbp_hit_o,
  output logic                        irq_o
);
  import dbr_pkg::*;

  function automatic logic [2:0] lowest_set(input logic [7:0] v);
    lowest_set = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        lowest_set = 3'(i);
      end
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      old[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
    merge = old;
  endfunction

  function automatic logic mapped(input logic [9:0] idx);
    mapped = (idx == IDX_SSP) || (idx == IDX_THREAD) || (idx == IDX_REGSEL) || (idx == IDX_CAUSE) ||
             (idx == IDX_RBP) || (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_CLR) || (idx == IDX_IRQ_EN);
  endfunction

  // Bus write side
  dbr_wr_state_type   wr_state_reg, wr_state_next;
  logic               aw_held_reg, aw_held_next;
  logic               w_held_reg, w_held_next;
  logic [9:0]         wr_idx_reg, wr_idx_next;
  logic [31:0]        wdata_reg, wdata_next;
  logic [3:0]         wstrb_reg, wstrb_next;
  logic               awready_reg, awready_next;
  logic               wready_reg, wready_next;
  logic               bvalid_reg, bvalid_next;
  logic [1:0]         bresp_reg, bresp_next;
  logic               commit;

  always_comb begin
    wr_state_next = wr_state_reg;
    aw_held_next  = aw_held_reg;
    w_held_next   = w_held_reg;
    wr_idx_next   = wr_idx_reg;
    wdata_next    = wdata_reg;
    wstrb_next    = wstrb_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    commit        = 1'b0;
    case (wr_state_reg)
      WR_COLLECT: begin
        if (s_axi_awvalid_i && awready_reg) begin
          aw_held_next = 1'b1;
          wr_idx_next  = s_axi_awaddr_i[11:2];
        end
        if (s_axi_wvalid_i && wready_reg) begin
          w_held_next = 1'b1;
          wdata_next  = s_axi_wdata_i;
          wstrb_next  = s_axi_wstrb_i;
        end
        if (aw_held_next && w_held_next) begin
          wr_state_next = WR_COMMIT;
        end
      end
      WR_COMMIT: begin
        commit        = 1'b1;
        aw_held_next  = 1'b0;
        w_held_next   = 1'b0;
        bvalid_next   = 1'b1;
        bresp_next    = mapped(wr_idx_reg) ? RESP_OKAY : RESP_DECERR;
        wr_state_next = WR_RESP;
      end
      WR_RESP: begin
        if (s_axi_bready_i) begin
          bvalid_next   = 1'b0;
          wr_state_next = WR_COLLECT;
        end
      end
      default: begin
        wr_state_next = WR_COLLECT;
      end
    endcase
    awready_next = (wr_state_next == WR_COLLECT) && !aw_held_next;
    wready_next  = (wr_state_next == WR_COLLECT) && !w_held_next;
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_state_reg <= WR_COLLECT;
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      wr_idx_reg   <= 10'h000;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      awready_reg  <= 1'b0;
      wready_reg   <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_held_reg  <= aw_held_next;
      w_held_reg   <= w_held_next;
      wr_idx_reg   <= wr_idx_next;
      wdata_reg    <= wdata_next;
      wstrb_reg    <= wstrb_next;
      awready_reg  <= awready_next;
      wready_reg   <= wready_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
    end
  end

  // Register file and debug event logic
  logic [31:0]        ssp_reg, ssp_next;
  logic [7:0]         thread_reg, thread_next;
  logic [4:0]         regsel_reg, regsel_next;
  dbr_cause_type      cause_reg, cause_next;
  logic [7:0]         mask_reg, mask_next;
  logic               cond_reg, cond_next;
  logic               en_reg, en_next;
  logic [IRQ_W-1:0]   stat_reg, stat_next;
  logic [IRQ_W-1:0]   irq_en_reg, irq_en_next;
  logic               entry_reg, entry_next;
  logic [7:0]         rbp_hit_reg, rbp_hit_next;
  logic               irq_reg, irq_next;
  logic [7:0]         rbp_fire;
  logic               entry;
  logic               dbg_wr;
  logic [31:0]        wmerged;
  logic [2:0]         ibp_low, dwp_low;

  always_comb begin
    ssp_next     = ssp_reg;
    thread_next  = thread_reg;
    regsel_next  = regsel_reg;
    cause_next   = cause_reg;
    mask_next    = mask_reg;
    cond_next    = cond_reg;
    en_next      = en_reg;
    irq_en_next  = irq_en_reg;
    // Condition B chosen by the control bit, gated by enable and mask
    rbp_fire     = (en_reg ? 8'hFF : 8'h00) & mask_reg & (cond_reg ? rbp_cond_b_i : rbp_cond_a_i);
    entry        = !debug_mode_i && (host_req_i || debug_call_instruction_i || (|ibp_hit_i) || (|dwp_hit_i) || (|rbp_fire));
    // Only four comparators per kind, so the top bit of the index is always zero
    ibp_low      = lowest_set({4'h0, ibp_hit_i});
    dwp_low      = lowest_set({4'h0, dwp_hit_i});
    // Debug fields ignore writes outside debug mode; irq registers stay open
    dbg_wr       = commit && debug_mode_i;
    wmerged      = 32'h0000_0000;
    stat_next    = stat_reg;
    case (wr_idx_reg)
      IDX_SSP:    wmerged = merge(ssp_reg, wdata_reg, wstrb_reg);
      IDX_THREAD: wmerged = merge({24'h00_0000, thread_reg}, wdata_reg, wstrb_reg);
      IDX_REGSEL: wmerged = merge({27'h000_0000, regsel_reg}, wdata_reg, wstrb_reg);
      IDX_CAUSE:  wmerged = merge({14'h0000, cause_reg.bp_index, cause_reg.thread, 5'h00, cause_reg.code},
                                  wdata_reg, wstrb_reg);
      IDX_RBP:    wmerged = merge({8'h00, mask_reg, 14'h0000, cond_reg, en_reg}, wdata_reg, wstrb_reg);
      IDX_IRQ_EN: wmerged = merge({30'h0000_0000, irq_en_reg}, wdata_reg, wstrb_reg);
      IDX_IRQ_CLR: wmerged = merge(32'h0000_0000, wdata_reg, wstrb_reg);
      default:    wmerged = 32'h0000_0000;
    endcase
    if (dbg_wr) begin
      case (wr_idx_reg)
        IDX_SSP:    ssp_next = wmerged;
        IDX_THREAD: thread_next = wmerged[THREAD_LSB +: 8];
        IDX_REGSEL: regsel_next = wmerged[REGSEL_LSB +: 5];
        IDX_CAUSE: begin
          cause_next.code     = wmerged[CAUSE_CODE_LSB +: 3];
          cause_next.thread   = wmerged[CAUSE_THR_LSB +: 8];
          cause_next.bp_index = wmerged[CAUSE_IDX_LSB +: 2];
        end
        IDX_RBP: begin
          mask_next = wmerged[RBP_MASK_LSB +: 8];
          cond_next = wmerged[RBP_COND_BIT];
          en_next   = wmerged[RBP_EN_BIT];
        end
        default: begin
        end
      endcase
    end
    if (commit && wr_idx_reg == IDX_IRQ_EN) begin
      irq_en_next = wmerged[IRQ_W-1:0];
    end
    if (commit && wr_idx_reg == IDX_IRQ_CLR) begin
      stat_next = stat_next & ~wmerged[IRQ_W-1:0];
    end
    // Hardware capture wins over a software write in the same cycle
    if (entry) begin
      if (host_req_i) begin
        cause_next = '{bp_index: 2'h0, thread: 8'h00, code: CAUSE_HOST};
      end else if (debug_call_instruction_i) begin
        cause_next = '{bp_index: 2'h0, thread: debug_call_instruction_thread_i, code: CAUSE_DEBUG_CALL_INSTRUCTION};
      end else if (|ibp_hit_i) begin
        cause_next = '{bp_index: ibp_low[1:0], thread: ibp_thread_i, code: CAUSE_IBP};
      end else if (|dwp_hit_i) begin
        cause_next = '{bp_index: dwp_low[1:0], thread: dwp_thread_i, code: CAUSE_DWP};
      end else begin
        cause_next = '{bp_index: 2'h0, thread: {5'h00, lowest_set(rbp_fire)}, code: CAUSE_RWP};
      end
    end
    entry_next   = entry;
    rbp_hit_next = rbp_fire;
    // Set wins over a clear landing in the same cycle
    stat_next[IRQ_ENTRY_BIT] = stat_next[IRQ_ENTRY_BIT] | entry;
    stat_next[IRQ_RBP_BIT]   = stat_next[IRQ_RBP_BIT] | (|rbp_fire);
    irq_next     = |(stat_next & irq_en_next);
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ssp_reg     <= SSP_RST;
      thread_reg  <= THREAD_RST;
      regsel_reg  <= REGSEL_RST;
      cause_reg   <= '{bp_index: 2'h0, thread: 8'h00, code: CAUSE_NONE};
      mask_reg    <= MASK_RST;
      cond_reg    <= 1'b0;
      en_reg      <= 1'b0;
      stat_reg    <= '0;
      irq_en_reg  <= '0;
      entry_reg   <= 1'b0;
      rbp_hit_reg <= 8'h00;
      irq_reg     <= 1'b0;
    end else begin
      ssp_reg     <= ssp_next;
      thread_reg  <= thread_next;
      regsel_reg  <= regsel_next;
      cause_reg   <= cause_next;
      mask_reg    <= mask_next;
      cond_reg    <= cond_next;
      en_reg      <= en_next;
      stat_reg    <= stat_next;
      irq_en_reg  <= irq_en_next;
      entry_reg   <= entry_next;
      rbp_hit_reg <= rbp_hit_next;
      irq_reg     <= irq_next;
    end
  end

  // Bus read side: one beat in flight, answered the cycle after it is taken
  logic               arready_reg, arready_next;
  logic               rvalid_reg, rvalid_next;
  logic [31:0]        rdata_reg, rdata_next;
  logic [1:0]         rresp_reg, rresp_next;
  logic [9:0]         rd_idx;

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    rd_idx      = s_axi_araddr_i[11:2];
    if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid_i && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = mapped(rd_idx) ? RESP_OKAY : RESP_DECERR;
      case (rd_idx)
        IDX_SSP:      rdata_next = ssp_reg;
        IDX_THREAD:   rdata_next = {24'h00_0000, thread_reg};
        IDX_REGSEL:   rdata_next = {27'h000_0000, regsel_reg};
        IDX_CAUSE:    rdata_next = {14'h0000, cause_reg.bp_index, cause_reg.thread, 5'h00, cause_reg.code};
        IDX_RBP:      rdata_next = {8'h00, mask_reg, 14'h0000, cond_reg, en_reg};
        IDX_IRQ_STAT: rdata_next = {30'h0000_0000, stat_reg};
        IDX_IRQ_EN:   rdata_next = {30'h0000_0000, irq_en_reg};
        default:      rdata_next = 32'h0000_0000;
      endcase
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = wready_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign debug_entry_o   = entry_reg;
  assign cause_o         = cause_reg;
  assign thread_sel_o    = thread_reg;
  assign reg_sel_o       = regsel_reg;
  assign rbp_hit_o       = rbp_hit_reg;
  assign irq_o           = irq_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence s_regsel_write;
    commit && debug_mode_i && wr_idx_reg == IDX_REGSEL && wstrb_reg[0];
  endsequence
  sequence s_quiet_host;
    !debug_mode_i && host_req_i;
  endsequence

  a_thread_sel_guard: assert property ($changed(thread_sel_o) |-> $past(commit && debug_mode_i))
    else $error("thread select changed without a debug-mode write");
  a_regsel_load: assert property (s_regsel_write |=> reg_sel_o == $past(wdata_reg[4:0]))
    else $error("register select did not load written value");
  a_host_cause_code: assert property (s_quiet_host |=> debug_entry_o && cause_o.code == CAUSE_HOST)
    else $error("host request not recorded as cause 1");
  a_call_index_zero: assert property (debug_entry_o && cause_o.code == CAUSE_DEBUG_CALL_INSTRUCTION |-> cause_o.bp_index == 2'h0)
    else $error("breakpoint index nonzero for debug call");
  a_lowest_ibp_wins: assert property (!debug_mode_i && !host_req_i && !debug_call_instruction_i && ibp_hit_i[1:0] == 2'b10
    |=> cause_o.code == CAUSE_IBP && cause_o.bp_index == 2'h1)
    else $error("simultaneous breakpoints not resolved to lowest");
  a_host_thread_zero: assert property (s_quiet_host |=> cause_o.thread == 8'h00 && cause_o.bp_index == 2'h0)
    else $error("host request recorded nonzero thread");
  a_mask_gates_hit: assert property (##1 (rbp_hit_o & ~$past(mask_reg)) == 8'h00)
    else $error("resource breakpoint fired for masked thread");
  a_cond_b_select: assert property (en_reg && cond_reg && rbp_cond_b_i == 8'h00 |=> rbp_hit_o == 8'h00)
    else $error("condition A used while condition B selected");
  a_disabled_quiet: assert property (!en_reg [*2] |=> rbp_hit_o == 8'h00)
    else $error("resource breakpoint fired while disabled");
  a_write_ack_time: assert property (commit |=> s_axi_bvalid_o ##0 !commit)
    else $error("write response not raised after commit");
endmodule

/* common/dbr_pkg.sv */
package dbr_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          THREADS       = 8;
  localparam int          BP_COUNT      = 4;
  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_SSP       = 10'h012;
  localparam logic [9:0]  IDX_THREAD    = 10'h013;
  localparam logic [9:0]  IDX_REGSEL    = 10'h014;
  localparam logic [9:0]  IDX_CAUSE     = 10'h015;
  localparam logic [9:0]  IDX_RBP       = 10'h09C;
  localparam logic [9:0]  IDX_IRQ_STAT  = 10'h0A0;
  localparam logic [9:0]  IDX_IRQ_CLR   = 10'h0A1;
  localparam logic [9:0]  IDX_IRQ_EN    = 10'h0A2;
  // Field positions and widths
  localparam int          THREAD_LSB    = 0;
  localparam int          REGSEL_LSB    = 0;
  localparam int          CAUSE_CODE_LSB = 0;
  localparam int          CAUSE_THR_LSB = 8;
  localparam int          CAUSE_IDX_LSB = 16;
  localparam int          RBP_EN_BIT    = 0;
  localparam int          RBP_COND_BIT  = 1;
  localparam int          RBP_MASK_LSB  = 16;
  localparam int          IRQ_ENTRY_BIT = 0;
  localparam int          IRQ_RBP_BIT   = 1;
  localparam int          IRQ_W         = 2;
  // Cause codes
  localparam logic [2:0]  CAUSE_NONE    = 3'h0;
  localparam logic [2:0]  CAUSE_HOST    = 3'h1;
  localparam logic [2:0]  CAUSE_DEBUG_CALL_INSTRUCTION   = 3'h2;
  localparam logic [2:0]  CAUSE_IBP     = 3'h3;
  localparam logic [2:0]  CAUSE_DWP     = 3'h4;
  localparam logic [2:0]  CAUSE_RWP     = 3'h5;
  // Reset values and bus response codes
  localparam logic [31:0] SSP_RST       = 32'h0000_0000;
  localparam logic [7:0]  THREAD_RST    = 8'h00;
  localparam logic [4:0]  REGSEL_RST    = 5'h00;
  localparam logic [7:0]  MASK_RST      = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  typedef struct packed {
    logic [1:0] bp_index;
    logic [7:0] thread;
    logic [2:0] code;
  } dbr_cause_type;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b00,
    WR_COMMIT  = 2'b01,
    WR_RESP    = 2'b11
  } dbr_wr_state_type;
endpackage

/* tb/dbr_host_model.sv */
`timescale 1ns/1ps
// Debugger host seen as an AXI4-Lite master; the bench calls its tasks
module dbr_host_model (
  input  wire logic        clock_i,
  output logic             awvalid_o,
  output logic [11:0]      awaddr_o,
  input  wire logic        awready_i,
  output logic             wvalid_o,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  input  wire logic        wready_i,
  input  wire logic        bvalid_i,
  input  wire logic [1:0]  bresp_i,
  output logic             bready_o,
  output logic             arvalid_o,
  output logic [11:0]      araddr_o,
  input  wire logic        arready_i,
  input  wire logic        rvalid_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  output logic             rready_o
);
  initial begin
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
    {awaddr_o, araddr_o} = 24'h00_0000;
    wdata_o = 32'h0000_0000;
    wstrb_o = 4'hf;
  end

  // A lag above zero raises the response ready late, so the answer must stand
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input int lag, output logic [1:0] r);
    int n;
    @(posedge clock_i);
    awvalid_o <= 1'b1;
    awaddr_o <= a;
    wvalid_o <= 1'b1;
    wdata_o <= d;
    bready_o <= (lag == 0);
    n = 0;
    do begin
      @(posedge clock_i);
      // Released lines carry a changed value, never the stale one
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
      n++;
      if (n == lag) bready_o <= 1'b1;
    end while (!(bvalid_i && bready_o));
    bready_o <= 1'b0;
    r = bresp_i;
  endtask

  task automatic rd(input logic [11:0] a, input int lag, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock_i);
    arvalid_o <= 1'b1;
    araddr_o <= a;
    rready_o <= (lag == 0);
    n = 0;
    do begin
      @(posedge clock_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
      n++;
      if (n == lag) rready_o <= 1'b1;
    end while (!(rvalid_i && rready_o));
    rready_o <= 1'b0;
    d = rdata_i;
    r = rresp_i;
  endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import dbr_pkg::*;
  typedef struct packed {
    logic       h;
    logic       dc;
    logic [3:0] ib;
    logic [3:0] dw;
    logic [7:0] t;
    logic [1:0] idx;
    logic [7:0] thr;
    logic [2:0] code;
  } dbr_ev_type;
  logic              clock_i, resetn_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, debug_mode, host_req, debug_call_instruction, entry, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb, ibp_hit, dwp_hit;
  logic [1:0]        bresp, rresp;
  logic [7:0]        debug_call_instruction_thr, ibp_thr, dwp_thr, cond_a, cond_b, thread_sel, rbp_hit;
  logic [4:0]        reg_sel;
  dbr_cause_type     cause;
  int                fails, checks, cycles;

  dbr_debug_regs dbr_debug_regs_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awaddr_i(awaddr), .s_axi_awready_o(awready),
    .s_axi_wvalid_i(wvalid), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wready_o(wready),
    .s_axi_bvalid_o(bvalid), .s_axi_bresp_o(bresp), .s_axi_bready_i(bready),
    .s_axi_arvalid_i(arvalid), .s_axi_araddr_i(araddr), .s_axi_arready_o(arready),
    .s_axi_rvalid_o(rvalid), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rready_i(rready),
    .debug_mode_i(debug_mode), .host_req_i(host_req), .debug_call_instruction_i(debug_call_instruction), .debug_call_instruction_thread_i(debug_call_instruction_thr),
    .ibp_hit_i(ibp_hit), .ibp_thread_i(ibp_thr), .dwp_hit_i(dwp_hit), .dwp_thread_i(dwp_thr),
    .rbp_cond_a_i(cond_a), .rbp_cond_b_i(cond_b), .debug_entry_o(entry), .cause_o(cause),
    .thread_sel_o(thread_sel), .reg_sel_o(reg_sel), .rbp_hit_o(rbp_hit), .irq_o(irq));

  dbr_host_model dbr_host_model_i (.clock_i(clock_i), .awvalid_o(awvalid), .awaddr_o(awaddr),
    .awready_i(awready), .wvalid_o(wvalid), .wdata_o(wdata), .wstrb_o(wstrb), .wready_i(wready),
    .bvalid_i(bvalid), .bresp_i(bresp), .bready_o(bready), .arvalid_o(arvalid), .araddr_o(araddr),
    .arready_i(arready), .rvalid_i(rvalid), .rdata_i(rdata), .rresp_i(rresp), .rready_o(rready));

  function automatic logic [11:0] ba(input logic [9:0] i);
    return {i, 2'b00};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input string what, input logic [9:0] i, input logic [31:0] exp, input int lag = 0);
    logic [31:0] d;
    logic [1:0]  r;
    dbr_host_model_i.rd(ba(i), lag, d, r);
    chk(what, exp, d);
    chk("rresp", 32'(RESP_OKAY), 32'(r));
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d, input int lag = 0);
    logic [1:0] r;
    dbr_host_model_i.wr(ba(i), d, lag, r);
    chk("bresp", 32'(RESP_OKAY), 32'(r));
  endtask

  task automatic set_mode(input logic m);
    @(posedge clock_i);
    debug_mode <= m;
  endtask

  task automatic pulse(input dbr_ev_type e);
    @(posedge clock_i);
    {host_req, debug_call_instruction, ibp_hit, dwp_hit} <= {e.h, e.dc, e.ib, e.dw};
    {debug_call_instruction_thr, ibp_thr, dwp_thr} <= {3{e.t}};
    @(posedge clock_i);
    {host_req, debug_call_instruction, ibp_hit, dwp_hit} <= 10'h000;
    #1;
  endtask

  task automatic rbp_fire(input logic [7:0] a, input logic [7:0] b, input logic [7:0] exp);
    @(posedge clock_i);
    {cond_a, cond_b} <= {a, b};
    @(posedge clock_i);
    {cond_a, cond_b} <= 16'h0000;
    #1 chk("rbp_hit", 32'(exp), 32'(rbp_hit));
  endtask

  task automatic t_reset();
    chk("irq", 32'h0000_0000, 32'(irq));
    rdchk("cause", IDX_CAUSE, 32'h0000_0000);
    rdchk("rbp_ctrl", IDX_RBP, 32'h0000_0000);
    rdchk("thread_sel", IDX_THREAD, 32'h0000_0000);
    rdchk("reg_sel", IDX_REGSEL, 32'h0000_0000);
  endtask

  task automatic t_sel();
    logic [31:0] d;
    logic [1:0]  r;
    set_mode(1'b1);
    wr(IDX_THREAD, 32'hffff_ffff, 3);
    rdchk("thread_sel", IDX_THREAD, 32'h0000_00ff, 4);
    chk("thread_sel_o", 32'h0000_00ff, 32'(thread_sel));
    wr(IDX_REGSEL, 32'hffff_ffff);
    rdchk("reg_sel", IDX_REGSEL, 32'h0000_001f);
    chk("reg_sel_o", 32'h0000_001f, 32'(reg_sel));
    wr(IDX_SSP, 32'ha5a5_5a5a);
    rdchk("ssp", IDX_SSP, 32'ha5a5_5a5a);
    set_mode(1'b0);
    wr(IDX_THREAD, 32'h0000_0012);
    rdchk("thread_sel", IDX_THREAD, 32'h0000_00ff);
    dbr_host_model_i.rd(12'h004, 0, d, r);
    chk("unmapped_rresp", 32'(RESP_DECERR), 32'(r));
    chk("unmapped_rdata", 32'h0000_0000, d);
    dbr_host_model_i.wr(12'h008, 32'h1234_5678, 0, r);
    chk("unmapped_bresp", 32'(RESP_DECERR), 32'(r));
  endtask

  task automatic t_causes();
    dbr_ev_type tab [5];
    tab = '{'{1'b1, 1'b1, 4'h0, 4'h0, 8'h09, 2'h0, 8'h00, CAUSE_HOST},
            '{1'b0, 1'b1, 4'h0, 4'h0, 8'h05, 2'h0, 8'h05, CAUSE_DEBUG_CALL_INSTRUCTION},
            '{1'b0, 1'b0, 4'h6, 4'h0, 8'h03, 2'h1, 8'h03, CAUSE_IBP},
            '{1'b0, 1'b0, 4'h0, 4'hc, 8'h07, 2'h2, 8'h07, CAUSE_DWP},
            '{1'b0, 1'b0, 4'h8, 4'h1, 8'h02, 2'h3, 8'h02, CAUSE_IBP}};
    foreach (tab[k]) begin
      pulse(tab[k]);
      chk("entry", 32'h0000_0001, 32'(entry));
      chk("cause_o", 32'({tab[k].idx, tab[k].thr, tab[k].code}), 32'(cause));
      // Host reads the cause after each entry
      rdchk("cause", IDX_CAUSE, {14'h0000, tab[k].idx, tab[k].thr, 5'h00, tab[k].code});
    end
  endtask

  task automatic t_rbp();
    set_mode(1'b1);
    wr(IDX_RBP, 32'hffff_ffff);
    rdchk("rbp_ctrl", IDX_RBP, 32'h00ff_0003);
    wr(IDX_RBP, 32'h000a_0001);
    set_mode(1'b0);
    rbp_fire(8'hff, 8'h00, 8'h0a);
    chk("cause_o", 32'({2'h0, 8'h01, CAUSE_RWP}), 32'(cause));
    rbp_fire(8'h00, 8'hff, 8'h00);
    set_mode(1'b1);
    wr(IDX_RBP, 32'h000a_0003);
    set_mode(1'b0);
    rbp_fire(8'h00, 8'hff, 8'h0a);
    rbp_fire(8'hff, 8'h00, 8'h00);
    set_mode(1'b1);
    wr(IDX_RBP, 32'h000a_0002);
    set_mode(1'b0);
    rbp_fire(8'hff, 8'hff, 8'h00);
    wr(IDX_RBP, 32'h000a_0003);
    rdchk("rbp_ctrl", IDX_RBP, 32'h000a_0002);
  endtask

  task automatic t_irq();
    chk("irq_masked", 32'h0000_0000, 32'(irq));
    rdchk("irq_stat", IDX_IRQ_STAT, 32'h0000_0003);
    wr(IDX_IRQ_EN, 32'h0000_0001);
    @(posedge clock_i);
    #1 chk("irq_on", 32'h0000_0001, 32'(irq));
    wr(IDX_IRQ_CLR, 32'h0000_0003);
    rdchk("irq_stat", IDX_IRQ_STAT, 32'h0000_0000);
    chk("irq_off", 32'h0000_0000, 32'(irq));
    pulse('{1'b1, 1'b0, 4'h0, 4'h0, 8'h00, 2'h0, 8'h00, CAUSE_HOST});
    chk("irq_raise", 32'h0000_0001, 32'(irq));
    rdchk("irq_stat", IDX_IRQ_STAT, 32'h0000_0001);
  endtask

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  initial begin
    {resetn_i, debug_mode, host_req, debug_call_instruction, ibp_hit, dwp_hit} = 12'h000;
    {debug_call_instruction_thr, ibp_thr, dwp_thr, cond_a, cond_b} = 40'h00_0000_0000;
    {fails, checks, cycles} = '0;
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_reset();
    t_sel();
    t_causes();
    t_rbp();
    t_irq();
    results();
  end
endmodule
